// File: shared/time_interval_arming_params.svh
// offsets, field positions, reset values and timing counts
`ifndef TIME_INTERVAL_ARMING_PARAMS_SVH
`define TIME_INTERVAL_ARMING_PARAMS_SVH
`define CTRL_ADDR 8'h00
`define EARLY_CFG_ADDR 8'h04
`define EARLY_DELAY_ADDR 8'h08
`define LAYER_CFG_ADDR 8'h0C
`define START_COUNT_ADDR 8'h10
`define START_TIME_ADDR 8'h14
`define STOP_COUNT_ADDR 8'h18
`define STOP_TIME_ADDR 8'h1C
`define STATUS_ADDR 8'h20
`define CTRL_GO_BIT 0
`define CTRL_ABORT_BIT 1
`define CTRL_LAYERED_BIT 2
`define CTRL_FUNC_OTHER_BIT 3
`define ECFG_START_EXT_BIT 0
`define ECFG_START_NEG_BIT 1
`define ECFG_STOP_TIMED_BIT 2
`define CLK_PERIOD_PS 4000
`define FINE_STEP_NS 100
`define COARSE_STEP_NS 10000
`define EDLY_RESET 32'h0000_03E8
`define EDLY_MIN 32'h0000_000A
`define EDLY_MIN_OLD 32'h0000_0064
`define EDLY_MAX 32'h000F_4240
`define EDLY_LONG_FROM 32'h0000_2710
`define EDLY_LONG_STEP 32'h0000_0064
`define COUNT_RESET 32'h0000_0001
`define COUNT_MAX 32'h05F5_E0FF
`define START_TIME_MAX 32'h0098_967F
`define STOP_TIME_MAX 32'h05F5_E100
`endif

// File: shared/time_interval_arming_pkg.sv
// types shared by the arming controller
package time_interval_arming_pkg;
   typedef enum logic [1:0] {
      SRC_IMM,
      SRC_TIME,
      SRC_EVENT
   } delay_src_e;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_OUT_START,
      ST_IN_START,
      ST_OUT_STOP,
      ST_IN_STOP
   } arm_state_e;
   typedef struct packed {
      logic ostart_ext;
      logic ostart_neg;
      delay_src_e istart;
      logic ostop_ext;
      logic ostop_neg;
      delay_src_e istop;
   } arm_cfg_s;
endpackage

// File: core/interval_measure_group.sv
// arming sequencer for the time-interval family of measurements
//
// Notes on behaviour
// - earlier variant: immediate/external start with immediate/timed stop only.
// - external start arms on the arm edge picked by start slope, rising.
// - start source selects immediate or external, resets to immediate.
// - stop source selects immediate or delay-timed stop, resets immediate.
// - stop source ignored for rise, fall, duty cycle, pulse width.
// - short stop delay up to 99.99 ms in 10 us steps.
// - long stop delay 100 ms to 10 s in 1 ms steps.
// - stop delay resets to 10 ms, used only when stop is timed.
// - old firmware strap raises minimum stop delay to 1 ms.
// - stop delay ignored for rise, fall, duty cycle, pulse width.
// - layered: immediate outer start forces immediate inner start, outer stop.
// - layered, non-interval functions: only outer start source and slope matter.
// - outer start slope resets rising, applies only when external.
// - inner start event delay counts 1 to 99,999,999 events, reset 1.
// - inner start time delay in 100 ns steps from 100 ns.
// - external outer stop arms on its own slope, resets rising.
`timescale 1ns/1ps
`include "time_interval_arming_params.svh"
module interval_measure_group (
   input wire logic CLK,
   input wire logic ARST_N,
   input wire logic [7:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   input wire logic EXT_ARM,
   input wire logic EVENT_IN,
   input wire logic OLD_FW_STRAP,
   output logic START_ARM,
   output logic STOP_ARM,
   output logic BUSY,
   output logic DONE
);
   localparam logic [11:0] FINE_CYC = 12'((`FINE_STEP_NS * 1000 +
      `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS);
   localparam logic [11:0] COARSE_CYC = 12'((`COARSE_STEP_NS * 1000 +
      `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS);

   function automatic logic [26:0] clampv(input logic [31:0] v,
      input logic [31:0] lo, input logic [31:0] hi);
      logic [31:0] r;
      r = (v < lo) ? lo : ((v > hi) ? hi : v);
      return r[26:0];
   endfunction

   logic layered_r, func_other_r, old_fw_r, strap_seen_r;
   logic e_start_ext_r, e_start_neg_r, e_stop_timed_r;
   logic [19:0] early_dly_r;
   time_interval_arming_pkg::arm_cfg_s lay_r, eff;
   logic [26:0] start_count_r, start_time_r, stop_count_r, stop_time_r;
   time_interval_arming_pkg::arm_state_e state_r;
   logic [26:0] cnt_r;
   logic [11:0] pre_r, unit_r;
   time_interval_arming_pkg::delay_src_e src_r;
   logic ext_q_r, evt_q_r, done_r;
   logic go, abort, ext_rise, ext_fall, start_hit, stop_hit, evt_rise;
   logic dly_done, unit_tick;
   logic [19:0] early_eff;
   logic [26:0] early_wr;
   logic [31:0] rd_nxt;

   assign go = WR && ADDR == `CTRL_ADDR && WDATA[`CTRL_GO_BIT];
   assign abort = WR && ADDR == `CTRL_ADDR && WDATA[`CTRL_ABORT_BIT];

   // strap caught once after reset release, not by the reset itself
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         strap_seen_r <= 1'b0;
         old_fw_r <= 1'b0;
      end else if (!strap_seen_r) begin
         strap_seen_r <= 1'b1;
         old_fw_r <= OLD_FW_STRAP;
      end
   end

   // long range snaps down to whole 1 ms steps
   always_comb begin
      early_wr = clampv(WDATA, `EDLY_MIN, `EDLY_MAX);
      if ({5'h00, early_wr} >= `EDLY_LONG_FROM) begin
         early_wr = early_wr - 27'(early_wr % `EDLY_LONG_STEP);
      end
   end

   // register writes; configuration is frozen while a sequence runs
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         layered_r <= 1'b0;
         func_other_r <= 1'b0;
         e_start_ext_r <= 1'b0;
         e_start_neg_r <= 1'b0;
         e_stop_timed_r <= 1'b0;
         early_dly_r <= 20'(`EDLY_RESET);
         lay_r <= '0;
         start_count_r <= 27'(`COUNT_RESET);
         start_time_r <= 27'(`COUNT_RESET);
         stop_count_r <= 27'(`COUNT_RESET);
         stop_time_r <= 27'(`COUNT_RESET);
      end else if (WR && state_r == time_interval_arming_pkg::ST_IDLE) begin
         case (ADDR)
            `CTRL_ADDR: begin
               layered_r <= WDATA[`CTRL_LAYERED_BIT];
               func_other_r <= WDATA[`CTRL_FUNC_OTHER_BIT];
            end
            `EARLY_CFG_ADDR: begin
               e_start_ext_r <= WDATA[`ECFG_START_EXT_BIT];
               e_start_neg_r <= WDATA[`ECFG_START_NEG_BIT];
               e_stop_timed_r <= WDATA[`ECFG_STOP_TIMED_BIT];
            end
            `EARLY_DELAY_ADDR: early_dly_r <= early_wr[19:0];
            `LAYER_CFG_ADDR: begin
               lay_r.ostart_ext <= WDATA[0];
               lay_r.ostart_neg <= WDATA[1];
               // an out-of-range source code falls back to immediate
               lay_r.istart <= (WDATA[3:2] == 2'h3) ?
                  time_interval_arming_pkg::SRC_IMM :
                  time_interval_arming_pkg::delay_src_e'(WDATA[3:2]);
               lay_r.ostop_ext <= WDATA[4];
               lay_r.ostop_neg <= WDATA[5];
               lay_r.istop <= (WDATA[7:6] == 2'h3) ?
                  time_interval_arming_pkg::SRC_IMM :
                  time_interval_arming_pkg::delay_src_e'(WDATA[7:6]);
            end
            `START_COUNT_ADDR:
               start_count_r <= clampv(WDATA, `COUNT_RESET, `COUNT_MAX);
            `START_TIME_ADDR:
               start_time_r <= clampv(WDATA, `COUNT_RESET,
                  `START_TIME_MAX);
            `STOP_COUNT_ADDR:
               stop_count_r <= clampv(WDATA, `COUNT_RESET, `COUNT_MAX);
            `STOP_TIME_ADDR:
               stop_time_r <= clampv(WDATA, `COUNT_RESET, `STOP_TIME_MAX);
            default: ;
         endcase
      end
   end

   // minimum applied at use, so a late strap value still takes hold
   assign early_eff = (old_fw_r && {12'h000, early_dly_r} < `EDLY_MIN_OLD) ?
      20'(`EDLY_MIN_OLD) : early_dly_r;

   // effective arming layers for the selected variant and function
   always_comb begin
      eff = lay_r;
      if (!layered_r) begin
         eff.ostart_ext = e_start_ext_r;
         eff.ostart_neg = e_start_ext_r && e_start_neg_r;
         eff.istart = time_interval_arming_pkg::SRC_IMM;
         eff.ostop_ext = 1'b0;
         eff.ostop_neg = 1'b0;
         eff.istop = (e_stop_timed_r && !func_other_r) ?
            time_interval_arming_pkg::SRC_TIME :
            time_interval_arming_pkg::SRC_IMM;
      end else begin
         eff.ostart_neg = lay_r.ostart_ext && lay_r.ostart_neg;
         if (!lay_r.ostart_ext || func_other_r) begin
            eff.istart = time_interval_arming_pkg::SRC_IMM;
            eff.ostop_ext = 1'b0;
         end
         eff.ostop_neg = eff.ostop_ext && lay_r.ostop_neg;
         if (func_other_r) begin
            eff.istop = time_interval_arming_pkg::SRC_IMM;
         end
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         ext_q_r <= 1'b0;
         evt_q_r <= 1'b0;
      end else begin
         ext_q_r <= EXT_ARM;
         evt_q_r <= EVENT_IN;
      end
   end

   assign ext_rise = EXT_ARM && !ext_q_r;
   assign ext_fall = !EXT_ARM && ext_q_r;
   assign start_hit = !eff.ostart_ext ||
      (eff.ostart_neg ? ext_fall : ext_rise);
   assign stop_hit = !eff.ostop_ext ||
      (eff.ostop_neg ? ext_fall : ext_rise);
   assign evt_rise = EVENT_IN && !evt_q_r;
   assign unit_tick = pre_r == unit_r - 12'h001;
   assign dly_done = src_r == time_interval_arming_pkg::SRC_IMM ||
      cnt_r == 27'h0000000;

   // sequencer
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         state_r <= time_interval_arming_pkg::ST_IDLE;
      end else if (abort) begin
         state_r <= time_interval_arming_pkg::ST_IDLE;
      end else begin
         case (state_r)
            time_interval_arming_pkg::ST_IDLE:
               if (go) begin
                  state_r <= time_interval_arming_pkg::ST_OUT_START;
               end
            time_interval_arming_pkg::ST_OUT_START:
               if (start_hit) begin
                  state_r <= time_interval_arming_pkg::ST_IN_START;
               end
            time_interval_arming_pkg::ST_IN_START:
               if (dly_done) begin
                  state_r <= time_interval_arming_pkg::ST_OUT_STOP;
               end
            time_interval_arming_pkg::ST_OUT_STOP:
               if (stop_hit) begin
                  state_r <= time_interval_arming_pkg::ST_IN_STOP;
               end
            time_interval_arming_pkg::ST_IN_STOP:
               if (dly_done) begin
                  state_r <= time_interval_arming_pkg::ST_IDLE;
               end
            default: state_r <= time_interval_arming_pkg::ST_IDLE;
         endcase
      end
   end

   // shared delay counter, loaded as each inner layer begins
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         cnt_r <= '0;
         pre_r <= '0;
         unit_r <= FINE_CYC;
         src_r <= time_interval_arming_pkg::SRC_IMM;
      end else if (state_r == time_interval_arming_pkg::ST_OUT_START &&
         start_hit) begin
         src_r <= eff.istart;
         unit_r <= FINE_CYC;
         pre_r <= '0;
         cnt_r <= (eff.istart == time_interval_arming_pkg::SRC_TIME) ?
            start_time_r : start_count_r;
      end else if (state_r == time_interval_arming_pkg::ST_OUT_STOP &&
         stop_hit) begin
         src_r <= eff.istop;
         pre_r <= '0;
         unit_r <= layered_r ? FINE_CYC : COARSE_CYC;
         if (!layered_r) begin
            cnt_r <= {7'h00, early_eff};
         end else if (eff.istop == time_interval_arming_pkg::SRC_TIME) begin
            cnt_r <= stop_time_r;
         end else begin
            cnt_r <= stop_count_r;
         end
      end else if (!dly_done) begin
         if (src_r == time_interval_arming_pkg::SRC_TIME) begin
            pre_r <= unit_tick ? 12'h000 : pre_r + 12'h001;
            if (unit_tick) begin
               cnt_r <= cnt_r - 27'h0000001;
            end
         end else if (evt_rise) begin
            cnt_r <= cnt_r - 27'h0000001;
         end
      end
   end

   // arm strobes and status; done set beats the clear from go
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         START_ARM <= 1'b0;
         STOP_ARM <= 1'b0;
         BUSY <= 1'b0;
         done_r <= 1'b0;
      end else begin
         START_ARM <= !abort && dly_done &&
            state_r == time_interval_arming_pkg::ST_IN_START;
         STOP_ARM <= !abort && dly_done &&
            state_r == time_interval_arming_pkg::ST_IN_STOP;
         BUSY <= abort ? 1'b0 :
            (state_r != time_interval_arming_pkg::ST_IDLE || go) &&
            !(state_r == time_interval_arming_pkg::ST_IN_STOP && dly_done);
         if (!abort && dly_done &&
            state_r == time_interval_arming_pkg::ST_IN_STOP) begin
            done_r <= 1'b1;
         end else if (go && state_r == time_interval_arming_pkg::ST_IDLE) begin
            done_r <= 1'b0;
         end
      end
   end
   assign DONE = done_r;

   always_comb begin
      rd_nxt = 32'h00000000;
      case (ADDR)
         `CTRL_ADDR: rd_nxt = {28'h0, func_other_r, layered_r, 2'h0};
         `EARLY_CFG_ADDR:
            rd_nxt = {29'h0, e_stop_timed_r, e_start_neg_r, e_start_ext_r};
         `EARLY_DELAY_ADDR: rd_nxt = {12'h000, early_dly_r};
         `LAYER_CFG_ADDR: rd_nxt = {24'h0, lay_r.istop, lay_r.ostop_neg,
            lay_r.ostop_ext, lay_r.istart, lay_r.ostart_neg, lay_r.ostart_ext};
         `START_COUNT_ADDR: rd_nxt = {5'h00, start_count_r};
         `START_TIME_ADDR: rd_nxt = {5'h00, start_time_r};
         `STOP_COUNT_ADDR: rd_nxt = {5'h00, stop_count_r};
         `STOP_TIME_ADDR: rd_nxt = {5'h00, stop_time_r};
         `STATUS_ADDR: rd_nxt = {26'h0, 3'(state_r), old_fw_r, done_r, BUSY};
         default: rd_nxt = 32'h00000000;
      endcase
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         RDATA <= '0;
      end else begin
         RDATA <= RD ? rd_nxt : 32'h00000000;
      end
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!ARST_N);

   a_early_pairs: assert property (!layered_r |->
      eff.istart == time_interval_arming_pkg::SRC_IMM && !eff.ostop_ext &&
      eff.istop != time_interval_arming_pkg::SRC_EVENT)
      else $error("earlier variant pairing broken");
   a_start_edge: assert property (
      state_r == time_interval_arming_pkg::ST_OUT_START && eff.ostart_ext &&
      !(eff.ostart_neg ? ext_fall : ext_rise) && !abort |=>
      state_r == time_interval_arming_pkg::ST_OUT_START)
      else $error("start armed without the chosen edge");
   a_start_imm: assert property (
      state_r == time_interval_arming_pkg::ST_OUT_START && !eff.ostart_ext &&
      !abort |=> state_r == time_interval_arming_pkg::ST_IN_START)
      else $error("immediate start did not pass");
   a_stop_timed: assert property (!layered_r && !func_other_r |->
      (eff.istop == time_interval_arming_pkg::SRC_TIME) ==
      e_stop_timed_r)
      else $error("stop source not followed");
   a_other_func: assert property (func_other_r |->
      eff.istop == time_interval_arming_pkg::SRC_IMM &&
      eff.istart == time_interval_arming_pkg::SRC_IMM &&
      !eff.ostop_ext)
      else $error("other function used stop settings");
   a_delay_range: assert property (
      {12'h000, early_dly_r} >= `EDLY_MIN &&
      {12'h000, early_dly_r} <= `EDLY_MAX &&
      ({12'h000, early_dly_r} < `EDLY_LONG_FROM ||
      {12'h000, early_dly_r} % `EDLY_LONG_STEP == 0))
      else $error("stop delay out of range");
   a_old_min: assert property (old_fw_r |->
      {12'h000, early_eff} >= `EDLY_MIN_OLD)
      else $error("old firmware minimum not enforced");
   a_layer_force: assert property (layered_r && !lay_r.ostart_ext |->
      eff.istart == time_interval_arming_pkg::SRC_IMM && !eff.ostop_ext)
      else $error("immediate outer start did not force layers");
   a_count_min: assert property (start_count_r != '0 &&
      start_time_r != '0)
      else $error("start delay value zero");
   a_tick_pace: assert property (state_r ==
      time_interval_arming_pkg::ST_IN_START &&
      src_r == time_interval_arming_pkg::SRC_TIME && !dly_done &&
      !unit_tick && !abort |=> $stable(cnt_r))
      else $error("time delay counted off its unit");
   a_start_order: assert property (START_ARM |->
      $past(state_r) == time_interval_arming_pkg::ST_IN_START &&
      state_r == time_interval_arming_pkg::ST_OUT_STOP)
      else $error("start arm out of order");
   a_stop_order: assert property (STOP_ARM |-> DONE && !BUSY &&
      state_r == time_interval_arming_pkg::ST_IDLE)
      else $error("stop arm out of order");

   c_plain_run: cover property (START_ARM ##[1:20] STOP_ARM);
   c_ext_start: cover property (eff.ostart_ext &&
      state_r == time_interval_arming_pkg::ST_OUT_START ##1 START_ARM);
   c_event_stop: cover property (src_r ==
      time_interval_arming_pkg::SRC_EVENT ##[1:50] STOP_ARM);
   c_abort: cover property (BUSY ##1 abort);
endmodule

// File: testbench/arm_model.sv
// behavioural source of the external arm and event lines
`timescale 1ns/1ps
module arm_model (
   input wire logic clk,
   output logic ext_arm,
   output logic event_in
);
   initial begin
      ext_arm = 1'b0;
      event_in = 1'b0;
   end
   // level held between edges; the sequencer only reacts to changes
   task automatic drive(input logic v);
      @(posedge clk);
      ext_arm <= v;
      #1;
   endtask
   // low cycle between pulses so each rise is a distinct event
   task automatic pulse(input int n);
      repeat (n) begin
         @(posedge clk);
         event_in <= ~event_in;
         @(posedge clk);
         event_in <= ~event_in;
      end
      @(posedge clk);
      #1;
   endtask
endmodule

// File: testbench/testbench.sv
// self-checking bench for the interval arming sequencer
`timescale 1ns/1ps
`include "time_interval_arming_params.svh"
module testbench;
   localparam int LIMIT = 80000;
   localparam int UL = `FINE_STEP_NS * 1000 / `CLK_PERIOD_PS;
   localparam int UE = `COARSE_STEP_NS * 1000 / `CLK_PERIOD_PS;
   localparam logic [7:0] RA [10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10,
      8'h14, 8'h18, 8'h1C, 8'h20, 8'h24};
   localparam logic [31:0] RV [10] = '{32'h0, 32'h0, `EDLY_RESET, 32'h0,
      `COUNT_RESET, 32'h1, 32'h1, 32'h1, 32'h0, 32'h0};
   localparam logic [31:0] CORN [7] = '{32'h0, 32'h5, 32'hA, 32'h270F,
      32'h2710, 32'h3039, 32'h1E8480};
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic strap = 1'b0;
   logic [31:0] rdata;
   logic [31:0] seed = 32'h8081;
   logic ext_arm, event_in, start_arm, stop_arm, busy, done;
   int n_fail = 0;
   int compares = 0;
   int cyc = 0, n_sa = 0, n_so = 0, t_sa = 0, t_so = 0;
   int b_sa = 0, b_so = 0, t_go = 0;

   always #2 clk = ~clk;

   interval_measure_group interval_measure_group_inst (
      .CLK(clk), .ARST_N(arst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
      .RD(rd), .RDATA(rdata), .EXT_ARM(ext_arm), .EVENT_IN(event_in),
      .OLD_FW_STRAP(strap), .START_ARM(start_arm), .STOP_ARM(stop_arm),
      .BUSY(busy), .DONE(done));
   arm_model arm_model_inst (
      .clk(clk), .ext_arm(ext_arm), .event_in(event_in));

   // pulse outputs stand one cycle, so count them on every edge
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (start_arm === 1'b1) begin
         n_sa <= n_sa + 1;
         t_sa <= cyc;
      end
      if (stop_arm === 1'b1) begin
         n_so <= n_so + 1;
         t_so <= cyc;
      end
   end

   always @(posedge clk) begin
      if (cyc == LIMIT) begin
         n_fail++;
         $display("ERROR timeout at t=%0t", $time);
         give_verdict();
      end
   end

   task automatic give_verdict();
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic logic [31:0] edly(input logic [31:0] x);
      if (x < `EDLY_MIN) return `EDLY_MIN;
      if (x > `EDLY_MAX) return `EDLY_MAX;
      if (x >= `EDLY_LONG_FROM) return x - x % `EDLY_LONG_STEP;
      return x;
   endfunction

   function automatic logic [31:0] inr(input int x, input int lo,
      input int hi);
      return {31'h0, (x >= lo && x <= hi)};
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wait_n(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask

   task automatic wreg(input logic [7:0] a, input logic [31:0] x);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= x;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask

   task automatic rreg(input logic [7:0] a, output logic [31:0] x);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      x = rdata;
   endtask

   task automatic wchk(input logic [7:0] a, input logic [31:0] x,
      input logic [31:0] e);
      logic [31:0] r;
      wreg(a, x);
      rreg(a, r);
      chk(r, e);
   endtask

   task automatic go(input logic [31:0] c);
      b_sa = n_sa;
      b_so = n_so;
      wreg(`CTRL_ADDR, c | 32'h1);
      t_go = cyc;
   endtask

   task automatic wait_idle();
      int i;
      for (i = 0; i < 40000 && busy !== 1'b0; i++) wait_n(1);
      wait_n(1);
   endtask

   // wrong-sense edge first, so a swapped slope shows as an early arm
   task automatic run_seq(input logic [31:0] c, input logic xs,
      input logic xp, input logic pol, output int ds, output int dso);
      int i;
      int te;
      if (xs) begin
         arm_model_inst.drive(~pol);
         wait_n(2);
      end
      go(c);
      te = t_go;
      if (xs) begin
         wait_n(4);
         arm_model_inst.drive(pol);
         wait_n(4);
         chk(n_sa - b_sa, 32'h0);
         arm_model_inst.drive(~pol);
         te = cyc;
      end
      ds = 0;
      if (xp) begin
         for (i = 0; i < 500 && n_sa == b_sa; i++) wait_n(1);
         ds = t_sa - te;
         wait_n(3);
         arm_model_inst.drive(pol);
         wait_n(4);
         chk(n_so - b_so, 32'h0);
         arm_model_inst.drive(~pol);
         te = cyc;
      end
      wait_idle();
      chk(n_sa - b_sa, 32'h1);
      chk(n_so - b_so, 32'h1);
      chk({30'h0, busy, done}, 32'h1);
      if (!xp) ds = t_sa - te;
      dso = t_so - (xp ? te : t_sa);
   endtask

   initial begin
      logic [31:0] d;
      logic [31:0] v;
      logic xs, tm, pol;
      int i, ds, dso;
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      for (i = 0; i < 10; i++) begin
         rreg(RA[i], d);
         chk(d, RV[i]);
      end
      $display("test reset values done");
      for (i = 0; i < 16; i++) begin
         v = (i < 7) ? CORN[i] : rnd() % 32'h124F80;
         wchk(`EARLY_DELAY_ADDR, v, edly(v));
      end
      wchk(`START_COUNT_ADDR, 32'h0, `COUNT_RESET);
      wchk(`START_COUNT_ADDR, 32'hFFFF_FFFF, `COUNT_MAX);
      wchk(`START_TIME_ADDR, 32'h0, 32'h1);
      $display("test delay ranges done");
      wchk(`EARLY_DELAY_ADDR, 32'hA, 32'hA);
      for (i = 0; i < 4; i++) begin
         xs = i[0];
         tm = i[1];
         pol = i[0] & i[1];
         wreg(`EARLY_CFG_ADDR, {29'h0, tm, pol, xs});
         run_seq(32'h0, xs, 1'b0, pol, ds, dso);
         chk(inr(ds, xs ? 1 : 2, xs ? 4 : 2), 32'h1);
         chk(dso, tm ? 10 * UE + 2 : 2);
      end
      $display("test earlier pairings done");
      wreg(`EARLY_CFG_ADDR, 32'h4);
      run_seq(32'h8, 1'b0, 1'b0, 1'b0, ds, dso);
      chk(dso, 32'h2);
      wreg(`STOP_TIME_ADDR, 32'h4);
      wreg(`LAYER_CFG_ADDR, 32'h58);
      run_seq(32'hC, 1'b0, 1'b0, 1'b0, ds, dso);
      chk(ds * 256 + dso, 2 * 256 + 2);
      run_seq(32'h4, 1'b0, 1'b0, 1'b0, ds, dso);
      chk(ds, 32'h2);
      chk(dso, 4 * UL + 2);
      $display("test forced sources done");
      wreg(`START_TIME_ADDR, 32'h4);
      wreg(`LAYER_CFG_ADDR, 32'h37);
      run_seq(32'h4, 1'b1, 1'b1, 1'b1, ds, dso);
      chk(inr(ds, 4 * UL + 1, 4 * UL + 4), 32'h1);
      chk(inr(dso, 1, 4), 32'h1);
      $display("test layered external done");
      wreg(`START_COUNT_ADDR, 32'h3);
      wreg(`STOP_COUNT_ADDR, 32'h2);
      wreg(`LAYER_CFG_ADDR, 32'h89);
      arm_model_inst.drive(1'b0);
      go(32'h4);
      wait_n(3);
      arm_model_inst.drive(1'b1);
      wait_n(3);
      arm_model_inst.pulse(2);
      chk(n_sa - b_sa, 32'h0);
      arm_model_inst.pulse(1);
      wait_n(6);
      chk(n_sa - b_sa, 32'h1);
      arm_model_inst.pulse(1);
      chk(n_so - b_so, 32'h0);
      arm_model_inst.pulse(1);
      wait_idle();
      chk(n_so - b_so, 32'h1);
      $display("test event delays done");
      // abort leaves the sticky flag as the go left it
      go(32'h0);
      wait_n(5);
      wreg(`CTRL_ADDR, 32'h2);
      wait_n(1);
      chk({30'h0, busy, done}, 32'h0);
      wait_n(3);
      chk(n_so - b_so, 32'h0);
      go(32'h0);
      wait_n(5);
      @(posedge clk);
      arst_n <= 1'b0;
      // flipped from its reset-time level, so the capture sees a change
      strap <= ~strap;
      wait_n(5);
      chk({30'h0, busy, start_arm | stop_arm}, 32'h0);
      arst_n <= 1'b1;
      wait_n(1);
      rreg(`STATUS_ADDR, d);
      chk(d, 32'h4);
      rreg(`EARLY_CFG_ADDR, d);
      chk(d, 32'h0);
      wchk(`EARLY_DELAY_ADDR, 32'hA, 32'hA);
      $display("test abort and strap done");
      give_verdict();
   end
endmodule
